// ==== src/muting_pkg.sv ====
// Shared constants for the muting sequencer
package muting_pkg;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          TIME_BASE_NS  = 1000000;
   localparam int          TICK_CYCLES   = TIME_BASE_NS / CLK_PERIOD_NS;
   localparam int          ADDR_W        = 5;
   localparam int          TIME_W        = 16;
   // Register offsets
   localparam logic [4:0]  CFG_OFS       = 5'h00;
   localparam logic [4:0]  CMD_OFS       = 5'h04;
   localparam logic [4:0]  STAT_OFS      = 5'h08;
   localparam logic [4:0]  CONC_OFS      = 5'h0c;
   localparam logic [4:0]  TOTAL_OFS     = 5'h10;
   // Configuration field positions
   localparam int          CFG_CROSSED   = 0;
   localparam int          CFG_PRE_EN    = 1;
   localparam int          CFG_DIR_DET   = 2;
   localparam int          CFG_REVERSE   = 3;
   localparam int          CFG_CONC_MON  = 4;
   localparam int          CFG_TOTAL_MON = 5;
   localparam int          CFG_END_DEV   = 6;
   localparam int          CFG_SEQ_MON   = 7;
   localparam int          CMD_OVERRIDE  = 0;
   // Error cause positions
   localparam int          ERR_CONC      = 0;
   localparam int          ERR_TOTAL     = 1;
   localparam int          ERR_DIR       = 2;
   localparam int          ERR_SEQ       = 3;
   // Status field positions
   localparam int          STAT_MUTE     = 0;
   localparam int          STAT_ERR      = 1;
   localparam int          STAT_CAUSE    = 4;
   localparam int          STAT_STATE    = 8;
   // Reset values
   localparam logic [7:0]  CFG_RESET     = 8'hf0;
   localparam logic [15:0] CONC_RESET    = 16'h0bb8;
   localparam logic [15:0] TOTAL_RESET   = 16'hea60;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FIRST,
      ST_SECOND,
      ST_DRAIN
   } mute_state_t;
endpackage

// ==== src/safety_muting_sequencer.sv ====
// Muting sequencer: sequential four-sensor and crossed two-sensor muting
`timescale 1ns/1ps
`default_nettype none
module safety_muting_sequencer
   import muting_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input  wire logic              sys_clk_in,
   input  wire logic              rst_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [31:0]       wr_data_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic [31:0]            rd_data_out,
   input  wire logic              first_pair_sensor_one_in,
   input  wire logic              first_pair_sensor_two_in,
   input  wire logic              second_pair_sensor_one_in,
   input  wire logic              second_pair_sensor_two_in,
   input  wire logic              pretrigger_sensor_in,
   input  wire logic              protective_safety_outputs_in,
   output logic                   output_enable_out,
   output logic                   muting_status_out,
   output logic                   muting_error_out,
   output logic                   fault_present_out
);
   mute_state_t        state_reg;
   mute_state_t        state_next;
   logic [7:0]         cfg_reg;
   logic [TIME_W-1:0]  conc_lim_reg;
   logic [TIME_W-1:0]  total_lim_reg;
   logic [31:0]        tick_cnt_reg;
   logic               tick;
   logic [TIME_W-1:0]  conc_cnt_reg;
   logic [TIME_W-1:0]  total_cnt_reg;
   logic [3:0]         cause_reg;
   logic [3:0]         cause_set;
   logic               rev_reg;
   logic               pre_seen_reg;
   logic               lead_one_reg;
   logic               lead_two_reg;
   logic               tripped_reg;
   logic               armed_reg;
   logic               complete;
   logic               override;
   logic               a_any, a_both, b_any, b_both, all_clear;
   logic               fst_both, sec_both;
   logic               pre_ok, order_ok, partial, muting;

   wire crossed  = cfg_reg[CFG_CROSSED];
   wire dir_det  = cfg_reg[CFG_DIR_DET];
   wire cfg_rev  = cfg_reg[CFG_REVERSE];
   wire osd_free = protective_safety_outputs_in;

   always_comb begin
      a_any     = first_pair_sensor_one_in | first_pair_sensor_two_in;
      a_both    = first_pair_sensor_one_in & first_pair_sensor_two_in;
      b_any     = second_pair_sensor_one_in | second_pair_sensor_two_in;
      b_both    = second_pair_sensor_one_in & second_pair_sensor_two_in;
      all_clear = !a_any && !b_any && !pretrigger_sensor_in && osd_free;
      // Crossed mode holds on the first pair; sequential holds on the far pair
      fst_both  = rev_reg ? b_both : a_both;
      sec_both  = (crossed || rev_reg) ? a_both : b_both;
      pre_ok    = !cfg_reg[CFG_PRE_EN] || pre_seen_reg;
      // One sensor must lead; simultaneous activation is no defined order
      order_ok  = dir_det ? (cfg_rev ? lead_two_reg : lead_one_reg)
                          : (lead_one_reg || lead_two_reg);
      partial   = (a_any && !a_both) || (!crossed && b_any && !b_both);
      muting    = (state_reg == ST_FIRST) || (state_reg == ST_SECOND);
      override  = wr_in && (addr_in == CMD_OFS) && wr_data_in[CMD_OVERRIDE];
   end

   // Millisecond time base for the monitors
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || tick_cnt_reg == 32'(TICK_DIV - 1)) begin
         tick_cnt_reg <= 32'h0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
   end
   assign tick = (tick_cnt_reg == 32'(TICK_DIV - 1));

   // Sequence control and error causes
   always_comb begin
      state_next = state_reg;
      cause_set  = 4'h0;
      complete   = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (cfg_reg[CFG_CONC_MON] && partial && conc_cnt_reg >= conc_lim_reg) begin
               cause_set[ERR_CONC] = 1'b1;
               state_next          = ST_DRAIN;
            end else if (crossed && a_both) begin
               if (order_ok && pre_ok) begin
                  state_next = ST_SECOND;
               end else begin
                  cause_set[dir_det ? ERR_DIR : ERR_SEQ] = 1'b1;
                  state_next = ST_DRAIN;
               end
            end else if (!crossed && a_both && b_both) begin
               if (cfg_reg[CFG_SEQ_MON]) begin
                  cause_set[ERR_SEQ] = 1'b1;
               end
               state_next = ST_DRAIN;
            end else if (!crossed && (a_both || b_both)) begin
               if (dir_det && (b_both != cfg_rev)) begin
                  cause_set[ERR_DIR] = 1'b1;
                  state_next         = ST_DRAIN;
               end else if (!pre_ok) begin
                  cause_set[ERR_SEQ] = 1'b1;
                  state_next         = ST_DRAIN;
               end else begin
                  state_next = ST_FIRST;
               end
            end
         end
         ST_FIRST: begin
            if (a_both && b_both) begin
               state_next = ST_SECOND;
            end else if (!fst_both) begin
               if (cfg_reg[CFG_SEQ_MON]) begin
                  cause_set[ERR_SEQ] = 1'b1;
               end
               state_next = ST_DRAIN;
            end
         end
         ST_SECOND: begin
            if (!sec_both) begin
               complete   = 1'b1;
               state_next = ST_DRAIN;
            end else if (cfg_reg[CFG_END_DEV] && tripped_reg && osd_free) begin
               complete   = 1'b1;
               state_next = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (!a_any && !b_any) begin
               state_next = ST_IDLE;
            end
         end
      endcase
      if (muting && cfg_reg[CFG_TOTAL_MON] && total_cnt_reg >= total_lim_reg) begin
         cause_set[ERR_TOTAL] = 1'b1;
         complete             = 1'b0;
         state_next           = ST_DRAIN;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Direction of the current sequential cycle
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rev_reg <= 1'b0;
      end else if (state_reg == ST_IDLE) begin
         rev_reg <= !crossed && b_both && !a_both;
      end
   end

   // Pre-trigger and lead sensor history, gathered only while idle
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || state_reg == ST_DRAIN) begin
         pre_seen_reg <= 1'b0;
         lead_one_reg <= 1'b0;
         lead_two_reg <= 1'b0;
      end else if (state_reg == ST_IDLE) begin
         if (pretrigger_sensor_in && !fst_both && !a_both) begin
            pre_seen_reg <= 1'b1;
         end
         if (!a_any) begin
            lead_one_reg <= 1'b0;
            lead_two_reg <= 1'b0;
         end else if (!lead_one_reg && !lead_two_reg && !a_both) begin
            lead_one_reg <= first_pair_sensor_one_in;
            lead_two_reg <= first_pair_sensor_two_in;
         end
      end
   end

   // Concurrence and total muting timers
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || !partial || state_reg != ST_IDLE) begin
         conc_cnt_reg <= '0;
      end else if (tick && conc_cnt_reg != '1) begin
         conc_cnt_reg <= conc_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in || !muting) begin
         total_cnt_reg <= '0;
      end else if (tick && total_cnt_reg != '1) begin
         total_cnt_reg <= total_cnt_reg + 1'b1;
      end
   end

   // Protective device interrupted during this muting cycle
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || !muting) begin
         tripped_reg <= 1'b0;
      end else if (!osd_free) begin
         tripped_reg <= 1'b1;
      end
   end

   // Error causes: a new cause always beats a clear in the same cycle
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         armed_reg <= 1'b0;
      end else if (cause_reg == 4'h0) begin
         armed_reg <= 1'b0;
      end else if (all_clear && !muting) begin
         armed_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cause_reg <= 4'h0;
      end else if (override || (complete && armed_reg)) begin
         cause_reg <= cause_set;
      end else begin
         cause_reg <= cause_reg | cause_set;
      end
   end

   // Outputs straight from flip-flops, following the next state
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         output_enable_out <= 1'b0;
         muting_status_out <= 1'b0;
         muting_error_out  <= 1'b0;
         fault_present_out <= 1'b0;
      end else begin
         muting_status_out <= (state_next == ST_FIRST) || (state_next == ST_SECOND);
         muting_error_out  <= (override || (complete && armed_reg)) ? |cause_set
                                                                  : |(cause_reg | cause_set);
         fault_present_out <= (override || (complete && armed_reg)) ? |cause_set
                                                                  : |(cause_reg | cause_set);
         output_enable_out <= !(override || (complete && armed_reg) ? |cause_set
                                                                  : |(cause_reg | cause_set))
                              && (osd_free || state_next == ST_FIRST
                                  || state_next == ST_SECOND);
      end
   end

   // Register port
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cfg_reg       <= CFG_RESET;
         conc_lim_reg  <= CONC_RESET;
         total_lim_reg <= TOTAL_RESET;
      end else if (wr_in) begin
         unique case (addr_in)
            CFG_OFS:   cfg_reg       <= wr_data_in[7:0];
            CONC_OFS:  conc_lim_reg  <= wr_data_in[TIME_W-1:0];
            TOTAL_OFS: total_lim_reg <= wr_data_in[TIME_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in || !rd_in) begin
         rd_data_out <= 32'h0;
      end else begin
         unique case (addr_in)
            CFG_OFS:   rd_data_out <= {24'h0, cfg_reg};
            STAT_OFS:  rd_data_out <= {22'h0, state_reg, cause_reg, 2'h0,
                                       muting_error_out, muting_status_out};
            CONC_OFS:  rd_data_out <= {16'h0, conc_lim_reg};
            TOTAL_OFS: rd_data_out <= {16'h0, total_lim_reg};
            default:   rd_data_out <= 32'h0;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence first_pair_closes_s;
      !crossed && state_reg == ST_IDLE && !rev_reg ##0 a_both && !b_any;
   endsequence

   sequence handover_s;
      state_reg == ST_FIRST ##0 a_both && b_both;
   endsequence

   seq_start_a: assert property (first_pair_closes_s ##0 pre_ok && !(dir_det && cfg_rev)
      && !(cfg_reg[CFG_CONC_MON] && partial) && !(muting && cfg_reg[CFG_TOTAL_MON])
      |=> state_reg == ST_FIRST ##0 muting_status_out)
      else $error("sequential cycle did not start");

   handover_gate_a: assert property (state_reg == ST_FIRST && state_next == ST_SECOND
      |-> a_both && b_both)
      else $error("handover without all four sensors");

   handover_take_a: assert property (handover_s ##0 !(cfg_reg[CFG_TOTAL_MON] && total_cnt_reg >= total_lim_reg)
      |=> state_reg == ST_SECOND) else $error("handover to second pair missed");

   hold_second_a: assert property (state_reg == ST_SECOND && !crossed && !sec_both
      |=> !muting_status_out)
      else $error("muting kept after second pair lost");

   pre_order_a: assert property (state_reg == ST_IDLE && state_next != ST_IDLE
      && state_next != ST_DRAIN && cfg_reg[CFG_PRE_EN] |-> pre_seen_reg)
      else $error("muting started without pre-trigger");

   dir_block_a: assert property (state_reg == ST_IDLE && !crossed && dir_det && !cfg_rev
      && b_both && !a_any |=> state_reg == ST_DRAIN && cause_reg[ERR_DIR])
      else $error("wrong direction accepted");

   total_limit_a: assert property (muting && cfg_reg[CFG_TOTAL_MON]
      && total_cnt_reg >= total_lim_reg |=> cause_reg[ERR_TOTAL] ##0 !muting)
      else $error("total muting time not enforced");

   valid_only_a: assert property (muting_status_out && !$past(muting_status_out)
      |-> $past(state_reg) == ST_IDLE && ($past(a_both) || $past(b_both)))
      else $error("muting from invalid order");

   cross_order_a: assert property (crossed && state_reg == ST_IDLE && state_next == ST_SECOND
      |-> (lead_one_reg || lead_two_reg) && a_both)
      else $error("crossed muting without lead sensor");

   cross_hold_a: assert property (crossed && muting_status_out && state_reg == ST_SECOND
      |-> $past(a_both))
      else $error("crossed muting without both sensors");

   cross_dir_a: assert property (crossed && dir_det && state_reg == ST_IDLE
      && state_next == ST_SECOND |-> cfg_rev ? lead_two_reg : lead_one_reg)
      else $error("crossed mode accepted reverse flow");

   err_sticky_a: assert property (muting_error_out && !override && !(complete && armed_reg)
      |=> muting_error_out)
      else $error("error cleared without clearing condition");

   err_gate_a: assert property (muting_error_out |-> !output_enable_out && fault_present_out)
      else $error("output enabled while error present");

   err_release_a: assert property (cause_reg != 4'h0 && override && cause_set == 4'h0
      |=> !muting_error_out)
      else $error("error not released by override");

   enable_a: assert property (cause_reg == 4'h0 && cause_set == 4'h0 && osd_free
      |=> output_enable_out)
      else $error("output enable missing with clear device");

   status_a: assert property (1'b1 |=> muting_status_out == muting)
      else $error("muting status differs from muting state");
endmodule
`default_nettype wire

// ==== test/conveyor_field_model.sv ====
// Far-side model: muting sensors, pre-trigger sensor and light curtain
`timescale 1ns/1ps
`default_nettype none
module conveyor_field_model (
   input  wire logic       sys_clk_in,
   input  wire logic [5:0] pattern_in,
   output wire logic       first_one_out,
   output wire logic       first_two_out,
   output wire logic       second_one_out,
   output wire logic       second_two_out,
   output wire logic       pretrigger_out,
   output wire logic       curtain_clear_out
);
   // Levels move only on the clock edge, so the block never sees a change mid-cycle
   logic [5:0] level_reg = 6'h20;
   always @(posedge sys_clk_in) begin
      level_reg <= pattern_in;
   end
   assign {curtain_clear_out, pretrigger_out, second_two_out, second_one_out, first_two_out, first_one_out} = level_reg;
endmodule
`default_nettype wire

// ==== test/safety_muting_sequencer_test.sv ====
// Self-checking bench for the muting sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module safety_muting_sequencer_test;
   import muting_pkg::*;
   localparam logic [5:0] DEV = 6'h20;
   localparam logic [5:0] PRE = 6'h10;
   localparam logic [5:0] AP  = 6'h03;
   localparam logic [5:0] BP  = 6'h0c;
   logic                  sys_clk_in = 1'b0;
   logic                  rst_in     = 1'b1;
   logic                  wr_in      = 1'b0;
   logic                  rd_in      = 1'b0;
   logic [ADDR_W-1:0]     addr_in    = '0;
   logic [31:0]           wr_data_in = '0;
   logic [31:0]           rd_data_out;
   logic [31:0]           d;
   logic [5:0]            pat        = DEV;
   logic                  f_one, f_two, s_one, s_two, pre, dev, oe, ms, me, fp;
   int                    errors     = 0;
   int                    n_checks   = 0;
   int                    seed       = 71974;
   int                    cyc        = 0;

   always #5 sys_clk_in = ~sys_clk_in;

   conveyor_field_model conveyor_field_model_inst (.sys_clk_in(sys_clk_in), .pattern_in(pat),
      .first_one_out(f_one), .first_two_out(f_two), .second_one_out(s_one), .second_two_out(s_two),
      .pretrigger_out(pre), .curtain_clear_out(dev));
   // Ten cycles per tick keeps the timed monitors short
   safety_muting_sequencer #(.TICK_DIV(10)) safety_muting_sequencer_inst (.sys_clk_in(sys_clk_in),
      .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
      .rd_data_out(rd_data_out), .first_pair_sensor_one_in(f_one), .first_pair_sensor_two_in(f_two),
      .second_pair_sensor_one_in(s_one), .second_pair_sensor_two_in(s_two), .pretrigger_sensor_in(pre),
      .protective_safety_outputs_in(dev), .output_enable_out(oe), .muting_status_out(ms),
      .muting_error_out(me), .fault_present_out(fp));

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         stop_test();
      end
   end

   task automatic note(input string s);
      $display("test %s finished", s);
   endtask

   task automatic set_s(input logic [5:0] p);
      @(posedge sys_clk_in);
      pat <= p;
      @(posedge sys_clk_in);
      @(posedge sys_clk_in);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge sys_clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wr_data_in <= v;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a);
      @(posedge sys_clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      #1 d = rd_data_out;
   endtask

   task automatic hold();
      repeat ($random(seed) & 7) @(posedge sys_clk_in);
   endtask

   task automatic clr();
      set_s(DEV);
      `CHK(me, 1'b1)
      wr(CMD_OFS, 32'h1);
      @(posedge sys_clk_in);
      #1;
      `CHK({me, fp, oe}, 3'b001)
   endtask

   // Refused activation: no muting, error held until override
   task automatic bad(input logic [5:0] p, input logic [3:0] c);
      set_s(DEV | p);
      `CHK({ms, me, fp, oe}, 4'b0110)
      rd(STAT_OFS);
      if (c != 4'h0) `CHK(d[7:4], c)
      clr();
   endtask

   task automatic run_seq(input logic [5:0] f, input logic [5:0] s, input logic [5:0] p, input logic e);
      if (p != 6'h0) set_s(DEV | p);
      set_s(DEV | p | f);
      `CHK({ms, oe}, {1'b1, ~e})
      hold();
      set_s(DEV | f | s);
      rd(STAT_OFS);
      `CHK(d[9:8], 2'd2)
      set_s(DEV | s);
      `CHK(ms, 1'b1)
      hold();
      set_s(DEV | (s & (s - 6'h1)));
      `CHK(ms, 1'b0)
      set_s(DEV);
   endtask

   task automatic run_x(input logic [5:0] f);
      set_s(DEV | f);
      `CHK(ms, 1'b0)
      hold();
      set_s(DEV | AP);
      `CHK({ms, oe, me}, 3'b110)
      set_s(DEV | f);
      `CHK(ms, 1'b0)
      set_s(DEV);
   endtask

   initial begin
      repeat (6) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
      #1;
      `CHK({oe, ms, me}, 3'b100)
      rd(CFG_OFS);
      `CHK(d, {24'h0, CFG_RESET})
      rd(CONC_OFS);
      `CHK(d, {16'h0, CONC_RESET})
      rd(TOTAL_OFS);
      `CHK(d, {16'h0, TOTAL_RESET})
      wr(STAT_OFS, 32'hffffffff);
      rd(STAT_OFS);
      `CHK(d, 32'h0)
      rd(5'h14);
      `CHK(d, 32'h0)
      set_s(6'h00);
      `CHK(oe, 1'b0)
      note("registers");
      repeat (3) run_seq(AP, BP, 6'h0, 1'b0);
      run_seq(BP, AP, 6'h0, 1'b0);
      // Curtain broken after the handover, then clear again
      set_s(DEV | AP);
      set_s(DEV | AP | BP);
      set_s(AP | BP);
      `CHK({ms, oe}, 2'b11)
      set_s(DEV | AP | BP);
      `CHK({ms, me}, 2'b00)
      set_s(DEV);
      note("sequential");
      bad(AP | BP, 4'h8);
      set_s(DEV | AP | BP);
      set_s(DEV);
      run_seq(AP, BP, 6'h0, 1'b1);
      @(posedge sys_clk_in);
      #1;
      `CHK({me, fp, oe}, 3'b001)
      note("errors");
      wr(CFG_OFS, 32'hf2);
      bad(AP, 4'h8);
      run_seq(AP, BP, PRE, 1'b0);
      wr(CFG_OFS, 32'hfc);
      bad(AP, 4'h4);
      run_seq(BP, AP, 6'h0, 1'b0);
      note("pretrigger and direction");
      wr(CFG_OFS, 32'hf1);
      run_x(6'h01);
      bad(AP, 4'h8);
      wr(CFG_OFS, 32'hf5);
      run_x(6'h01);
      set_s(DEV | 6'h02);
      bad(AP, 4'h4);
      wr(CFG_OFS, 32'hfd);
      run_x(6'h02);
      wr(CFG_OFS, 32'hf3);
      set_s(DEV | 6'h01);
      bad(AP, 4'h8);
      note("crossed");
      wr(CFG_OFS, {24'h0, CFG_RESET});
      wr(TOTAL_OFS, 32'h3);
      set_s(DEV | AP);
      repeat (60) @(posedge sys_clk_in);
      #1;
      `CHK({ms, me, oe}, 3'b010)
      rd(STAT_OFS);
      `CHK(d[7:4], 4'h2)
      clr();
      wr(TOTAL_OFS, {16'h0, TOTAL_RESET});
      wr(CONC_OFS, 32'h2);
      set_s(DEV | 6'h01);
      repeat (60) @(posedge sys_clk_in);
      #1;
      `CHK({ms, me, oe}, 3'b010)
      rd(STAT_OFS);
      `CHK(d[7:4], 4'h1)
      clr();
      note("monitors");
      stop_test();
   end
endmodule
`default_nettype wire
